// ===== logic/antx_consts.vh
// constants for the next-page transmit register block
`ifndef ANTX_CONSTS_VH
`define ANTX_CONSTS_VH
`define ANTX_ADDR_W 5
`define ANTX_OFF_NP_PAGE 5'h07
`define ANTX_BIT_MORE 15
`define ANTX_BIT_ACK 14
`define ANTX_BIT_MSG 13
`define ANTX_BIT_ACK2 12
`define ANTX_BIT_TOGGLE 11
`define ANTX_CODE_W 11
`define ANTX_RST_MORE 1'b0
`define ANTX_RST_MSG 1'b1
`define ANTX_RST_ACK2 1'b0
`define ANTX_RST_CODE 11'h001
`endif

// ===== logic/antx_exch.v
// next-page exchange status tracker: acknowledge, toggle and last-page flags
`timescale 1ns/100ps
module antx_exch (
	// clock and reset
	input wire clk_sys,
	input wire nrst,
	// arbiter events and the stored more-pages bit
	input wire page_rx_ok,
	input wire page_sent,
	input wire exch_restart,
	input wire more_pages,
	// status
	output reg ack_q,
	output reg toggle_q,
	output reg last_sent_q
);
	always @(posedge clk_sys) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			toggle_q <= 1'b0;
			last_sent_q <= 1'b0;
		end else if (exch_restart) begin
			ack_q <= 1'b0;
			toggle_q <= 1'b0;
			last_sent_q <= 1'b0;
		end else begin
			if (page_rx_ok)
				ack_q <= 1'b1;
			else if (page_sent)
				ack_q <= 1'b0;
			if (page_sent) begin
				toggle_q <= ~toggle_q;
				last_sent_q <= ~more_pages;
			end
		end
	end
endmodule // antx_exch

// ===== logic/antx_np_reg.v
// next-page transmit register with management port and arbiter handoff
`timescale 1ns/100ps
`include "antx_consts.vh"

module antx_np_reg (
	// clock and reset
	input wire clk_sys,
	input wire nrst,
	// register port
	input wire [`ANTX_ADDR_W-1:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata_q,
	// legacy compatibility bit from the configuration register
	input wire legacy_mode,
	// arbiter side
	input wire page_rx_ok,
	input wire page_sent,
	input wire exch_restart,
	output reg [15:0] tx_page_q,
	output reg tx_page_valid_q
);
	// ************
	// handoff states
	// ************
	// idle: nothing loaded since reset or restart
	localparam HS_IDLE = 2'b00;
	// armed: a written page waits for the arbiter
	localparam HS_ARMED = 2'b01;
	// more: a page with more-pages set went out, software owes the next one
	localparam HS_MORE = 2'b10;
	// last: the final page went out, the exchange rests until software reloads
	localparam HS_LAST = 2'b11;

	// ************
	// storage and wires
	// ************
	reg more_q;
	reg more_d;
	reg msg_q;
	reg msg_d;
	reg ack2_q;
	reg ack2_d;
	reg [`ANTX_CODE_W-1:0] code_q;
	reg [`ANTX_CODE_W-1:0] code_d;
	reg [1:0] hs_q;
	reg [1:0] hs_d;
	reg valid_d;
	reg [15:0] rdata_d;
	wire ack_w;
	wire toggle_w;
	wire hit_w;
	wire wr_en_w;
	wire rd_en_w;
	wire [15:0] page_w;

	// ************
	// address decode
	// ************
	assign hit_w = (reg_addr == `ANTX_OFF_NP_PAGE);
	// legacy mode gates the strobe once, so every writable field sees the same lock
	assign wr_en_w = reg_wr && hit_w && !legacy_mode;
	assign rd_en_w = reg_rd && hit_w;

	// ************
	// exchange status
	// ************
	antx_exch u_exch (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.page_rx_ok(page_rx_ok),
		.page_sent(page_sent),
		.exch_restart(exch_restart),
		.more_pages(more_q),
		.ack_q(ack_w),
		.toggle_q(toggle_w),
		.last_sent_q()
	);

	// ************
	// page image
	// ************
	// read-only bits come live from the exchange tracker, writable bits from storage
	assign page_w[`ANTX_BIT_MORE] = more_q;
	assign page_w[`ANTX_BIT_ACK] = ack_w;
	assign page_w[`ANTX_BIT_MSG] = msg_q;
	assign page_w[`ANTX_BIT_ACK2] = ack2_q;
	assign page_w[`ANTX_BIT_TOGGLE] = toggle_w;
	assign page_w[`ANTX_CODE_W-1:0] = code_q;

	// ************
	// writable fields
	// ************
	// next values hold by default; only an unlocked write at this address moves them
	always @* begin
		more_d = more_q;
		msg_d = msg_q;
		ack2_d = ack2_q;
		code_d = code_q;
		if (wr_en_w) begin
			more_d = reg_wdata[`ANTX_BIT_MORE];
			msg_d = reg_wdata[`ANTX_BIT_MSG];
			ack2_d = reg_wdata[`ANTX_BIT_ACK2];
			code_d = reg_wdata[`ANTX_CODE_W-1:0];
		end
	end

	always @(posedge clk_sys) begin
		if (!nrst) begin
			more_q <= `ANTX_RST_MORE;
			msg_q <= `ANTX_RST_MSG;
			ack2_q <= `ANTX_RST_ACK2;
			code_q <= `ANTX_RST_CODE;
		end else begin
			more_q <= more_d;
			msg_q <= msg_d;
			ack2_q <= ack2_d;
			code_q <= code_d;
		end
	end

	// ************
	// page handoff
	// ************
	// a fresh write arms one page; a write in the same cycle as a send or restart
	// wins, so a new page is never lost behind the one just sent
	// limitation: no queue, a write while armed replaces the waiting page
	always @* begin
		hs_d = hs_q;
		case (hs_q)
			HS_IDLE: begin
				if (wr_en_w)
					hs_d = HS_ARMED;
			end
			HS_ARMED: begin
				if (wr_en_w)
					hs_d = HS_ARMED;
				else if (page_sent && more_q)
					hs_d = HS_MORE;
				else if (page_sent)
					hs_d = HS_LAST;
			end
			HS_MORE: begin
				if (wr_en_w)
					hs_d = HS_ARMED;
			end
			HS_LAST: begin
				// nothing further is offered after the final page until software reloads
				if (wr_en_w)
					hs_d = HS_ARMED;
			end
			default: begin
				hs_d = HS_IDLE;
			end
		endcase
		if (exch_restart && !wr_en_w)
			hs_d = HS_IDLE;
		// valid follows the registered state, so it lags a write by two edges
		valid_d = (hs_q == HS_ARMED);
	end

	always @(posedge clk_sys) begin
		if (!nrst) begin
			hs_q <= HS_IDLE;
		end else begin
			hs_q <= hs_d;
		end
	end

	always @(posedge clk_sys) begin
		if (!nrst) begin
			tx_page_q <= 16'h0000;
			tx_page_valid_q <= 1'b0;
		end else begin
			tx_page_q <= page_w;
			tx_page_valid_q <= valid_d;
		end
	end

	// ************
	// read path
	// ************
	// unmapped addresses and idle cycles read as zero, so a stale page never lingers
	always @* begin
		rdata_d = 16'h0000;
		case (rd_en_w)
			1'b1: rdata_d = page_w;
			default: rdata_d = 16'h0000;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!nrst) begin
			reg_rdata_q <= 16'h0000;
		end else begin
			reg_rdata_q <= rdata_d;
		end
	end
endmodule // antx_np_reg

// ===== verification/antx_monitor.sv
// port checks for the next-page transmit register
`timescale 1ns/100ps
`include "antx_consts.vh"
module antx_monitor (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// register port
	input wire logic [`ANTX_ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata_q,
	input wire logic legacy_mode,
	// arbiter side
	input wire logic page_rx_ok,
	input wire logic page_sent,
	input wire logic exch_restart,
	input wire logic [15:0] tx_page_q,
	input wire logic tx_page_valid_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence quiet;
		!(page_sent || page_rx_ok || exch_restart);
	endsequence
	sequence np_write;
		reg_wr && reg_addr == 7 && !legacy_mode;
	endsequence
	wr_load_a:
	assert property (np_write |-> ##2
		(tx_page_q & 16'hb7ff) == ($past(reg_wdata, 2) & 16'hb7ff)) else $error("bad load");
	last_page_a:
	assert property (page_sent && !reg_wr |-> ##2 !tx_page_valid_q) else $error("page kept");
	page_armed_a:
	assert property (np_write |-> ##2 tx_page_valid_q) else $error("page not armed");
	ack_set_a:
	assert property (page_rx_ok && !exch_restart |-> ##2 tx_page_q[14]) else $error("no ack");
	legacy_lock_a:
	assert property (!(page_sent || page_rx_ok || exch_restart) && reg_wr && legacy_mode
		##1 quiet |=> $stable(tx_page_q)) else $error("locked write");
	toggle_flip_a:
	assert property (page_sent && !exch_restart |-> ##2 tx_page_q[11] != $past(tx_page_q[11]))
		else $error("no toggle");
	read_data_a:
	assert property (reg_rd && reg_addr == 7 |=> reg_rdata_q == tx_page_q) else $error("bad read");
	read_idle_a:
	assert property (!reg_rd |=> reg_rdata_q == 16'h0000) else $error("stale read");
endmodule // antx_monitor

// ===== verification/tb_top.sv
// testbench for the next-page transmit register
`timescale 1ns/100ps
module tb_top;
	logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, legacy_mode = 0;
	logic page_rx_ok = 0, page_sent = 0, exch_restart = 0, tx_page_valid_q;
	logic [4:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, reg_rdata_q, tx_page_q, m, d;
	int error_cnt = 0, checks = 0, cyc = 0;
	always #50 clk_sys = ~clk_sys;
	logic v;
	antx_np_reg DUT (
		.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.legacy_mode(legacy_mode), .page_rx_ok(page_rx_ok), .page_sent(page_sent),
		.exch_restart(exch_restart), .tx_page_q(tx_page_q), .tx_page_valid_q(tx_page_valid_q)
	);
	task automatic stop_test;
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_sys) if (++cyc > 3000) begin
		error_cnt++;
		stop_test;
	end
	task automatic chk(input logic [15:0] g, e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1;
		@(posedge clk_sys) reg_wr <= 0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk_sys) reg_rd <= 0;
		#1 chk(reg_rdata_q, (a == 7) ? m : 16'h0000);
		chk(tx_page_q, m);
		chk({15'h0000, tx_page_valid_q}, {15'h0000, v});
	endtask
	task automatic pulse(input int k);
		@(posedge clk_sys);
		page_rx_ok <= (k == 0);
		page_sent <= (k == 1);
		exch_restart <= (k == 2);
		@(posedge clk_sys);
		page_rx_ok <= 0;
		page_sent <= 0;
		exch_restart <= 0;
	endtask
	task automatic load(input logic [15:0] x);
		wr(7, x);
		m = (x & 16'hb7ff) | (m & 16'h4800);
		v = 1;
	endtask
	initial begin
		void'($urandom(7));
		repeat (12) @(posedge clk_sys);
		nrst <= 1;
		m = 16'h2001;
		v = 0;
		rd(7);
		repeat (4) begin
			d = $urandom;
			load(d);
			rd(7);
		end
		$display("write test done");
		pulse(0);
		m[14] = 1;
		rd(7);
		load($urandom | 16'h8000);
		rd(7);
		pulse(1);
		m[14] = 0;
		m[11] = ~m[11];
		v = 0;
		rd(7);
		load($urandom & 16'h7fff);
		rd(7);
		pulse(1);
		m[11] = ~m[11];
		v = 0;
		rd(7);
		$display("exchange test done");
		@(posedge clk_sys) legacy_mode <= 1;
		wr(7, ~m);
		rd(7);
		@(posedge clk_sys) legacy_mode <= 0;
		wr(8, 16'hffff);
		rd(8);
		rd(7);
		pulse(2);
		m[11] = 0;
		m[14] = 0;
		rd(7);
		$display("lock test done");
		stop_test;
	end
endmodule // tb_top
bind antx_np_reg antx_monitor MON (
	.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .legacy_mode(legacy_mode),
	.page_rx_ok(page_rx_ok), .page_sent(page_sent), .exch_restart(exch_restart),
	.tx_page_q(tx_page_q), .tx_page_valid_q(tx_page_valid_q)
);
